// file: hw/dptc_pkg.sv
// shared constants and types for the defect pixel table corrector
package dptc_pkg;

    // table geometry and pixel widths
    localparam int DPTC_DEPTH   = 16;
    localparam int DPTC_COORD_W = 12;
    localparam int DPTC_PIX_W   = 12;
    localparam int DPTC_CNT_W   = $clog2(DPTC_DEPTH + 1);
    localparam int DPTC_IDX_W   = $clog2(DPTC_DEPTH);
    localparam int DPTC_NV_W    = 2 * DPTC_COORD_W;

    // full scale per pixel format
    localparam logic [DPTC_PIX_W-1:0] DPTC_FULL_8  = 12'h00FF;
    localparam logic [DPTC_PIX_W-1:0] DPTC_FULL_10 = 12'h03FF;
    localparam logic [DPTC_PIX_W-1:0] DPTC_FULL_12 = 12'h0FFF;
    localparam logic [DPTC_PIX_W-1:0] DPTC_ZERO    = 12'h0000;

    // factory calibrated list, values arbitrary
    localparam int DPTC_FACTORY_N = 4;
    localparam logic [DPTC_COORD_W-1:0] DPTC_FACTORY_COL [DPTC_FACTORY_N] =
        '{12'h0010, 12'h0123, 12'h0200, 12'h0345};
    localparam logic [DPTC_COORD_W-1:0] DPTC_FACTORY_ROW [DPTC_FACTORY_N] =
        '{12'h0004, 12'h0056, 12'h0100, 12'h01A0};

    typedef enum logic [1:0] {
        DPTC_M_AVERAGE,
        DPTC_M_HIGHLIGHT,
        DPTC_M_ZERO
    } dptc_method_type;

    typedef enum logic [1:0] {
        DPTC_FMT_8,
        DPTC_FMT_10,
        DPTC_FMT_12
    } dptc_format_type;

endpackage

// file: hw/dptc_tbl_if.sv
// active table as seen by the pixel path
`timescale 1ns/1ns
interface dptc_tbl_if
    import dptc_pkg::*;
#(
    parameter int DEPTH = DPTC_DEPTH
);
    logic [DPTC_COORD_W-1:0] col [DEPTH];
    logic [DPTC_COORD_W-1:0] row [DEPTH];
    logic [DPTC_CNT_W-1:0]   count;

    modport owner (output col, output row, output count);
    modport user  (input col, input row, input count);
endinterface

// file: hw/dptc_factory_rom.sv
// factory calibrated defect list lookup
`timescale 1ns/1ns
module dptc_factory_rom
    import dptc_pkg::*;
(
    input  wire logic [DPTC_IDX_W-1:0]   idx_i,
    output logic      [DPTC_COORD_W-1:0] col_o,
    output logic      [DPTC_COORD_W-1:0] row_o,
    output logic      [DPTC_CNT_W-1:0]   count_o
);
    always_comb
    begin
        col_o   = '0;
        row_o   = '0;
        count_o = DPTC_CNT_W'(DPTC_FACTORY_N);
        if (int'(idx_i) < DPTC_FACTORY_N)
        begin
            col_o = DPTC_FACTORY_COL[int'(idx_i)];
            row_o = DPTC_FACTORY_ROW[int'(idx_i)];
        end
    end
endmodule

// file: hw/dptc_pixel_fix.sv
// pixel stream correction against the active table
`timescale 1ns/1ns
module dptc_pixel_fix
    import dptc_pkg::*;
#(
    parameter int DEPTH = DPTC_DEPTH
)(
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    dptc_tbl_if.user                     tbl,
    // control
    input  wire logic                    enable_i,
    input  wire dptc_method_type         method_i,
    input  wire dptc_format_type         format_i,
    input  wire logic [DPTC_COORD_W-1:0] roi_col_i,
    input  wire logic [DPTC_COORD_W-1:0] roi_row_i,
    // stream in
    input  wire logic                    valid_i,
    input  wire logic [DPTC_PIX_W-1:0]   data_i,
    input  wire logic [DPTC_COORD_W-1:0] col_i,
    input  wire logic [DPTC_COORD_W-1:0] row_i,
    input  wire logic                    eol_i,
    // stream out
    output logic                         valid_o,
    output logic      [DPTC_PIX_W-1:0]   data_o,
    output logic      [DPTC_COORD_W-1:0] col_o,
    output logic      [DPTC_COORD_W-1:0] row_o
);
    logic                    cur_v_r, cur_v_nxt, cur_hit_r, cur_hit_nxt, cur_eol_r, cur_eol_nxt;
    logic                    cur_first_r, cur_first_nxt, first_r, first_nxt;
    logic [DPTC_PIX_W-1:0]   cur_d_r, cur_d_nxt, prev_d_r, prev_d_nxt, out_d_r, out_d_nxt;
    logic [DPTC_COORD_W-1:0] cur_c_r, cur_c_nxt, cur_w_r, cur_w_nxt;
    logic [DPTC_COORD_W-1:0] out_c_r, out_c_nxt, out_w_r, out_w_nxt;
    logic                    out_v_r, out_v_nxt, advance;
    logic [DPTC_PIX_W:0]     pair_sum;
    logic [DPTC_PIX_W-1:0]   neigh;

    // match only entries below the count
    function automatic logic listed(input logic [DPTC_COORD_W-1:0] c,
                                    input logic [DPTC_COORD_W-1:0] r);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < DEPTH; k++)
        begin
            if ((k < int'(tbl.count)) && (tbl.col[k] == c) && (tbl.row[k] == r))
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // a line end leaves without a right neighbour
    assign advance = cur_v_r && (valid_i || cur_eol_r);

    always_comb
    begin
        cur_v_nxt     = cur_v_r;
        cur_hit_nxt   = cur_hit_r;
        cur_eol_nxt   = cur_eol_r;
        cur_first_nxt = cur_first_r;
        first_nxt     = first_r;
        cur_d_nxt     = cur_d_r;
        prev_d_nxt    = prev_d_r;
        cur_c_nxt     = cur_c_r;
        cur_w_nxt     = cur_w_r;
        out_v_nxt     = 1'b0;
        out_d_nxt     = out_d_r;
        out_c_nxt     = out_c_r;
        out_w_nxt     = out_w_r;
        // mean of the left and right neighbours, or the one neighbour at a line start or end
        if (cur_first_r)
        begin
            pair_sum = {1'b0, data_i} + {1'b0, data_i};
        end
        else if (cur_eol_r || !valid_i)
        begin
            pair_sum = {1'b0, prev_d_r} + {1'b0, prev_d_r};
        end
        else
        begin
            pair_sum = {1'b0, prev_d_r} + {1'b0, data_i};
        end
        neigh = pair_sum[DPTC_PIX_W:1];
        if (advance)
        begin
            out_v_nxt  = 1'b1;
            out_c_nxt  = cur_c_r;
            out_w_nxt  = cur_w_r;
            out_d_nxt  = cur_d_r;
            prev_d_nxt = cur_d_r;
            cur_v_nxt  = 1'b0;
            if (enable_i && cur_hit_r)
            begin
                case (method_i)
                    DPTC_M_AVERAGE:   out_d_nxt = neigh;
                    DPTC_M_HIGHLIGHT: out_d_nxt = (format_i == DPTC_FMT_8)  ? DPTC_FULL_8 :
                                                  (format_i == DPTC_FMT_10) ? DPTC_FULL_10 :
                                                  DPTC_FULL_12;
                    default:          out_d_nxt = DPTC_ZERO;
                endcase
            end
        end
        if (valid_i)
        begin
            cur_hit_nxt   = listed(col_i + roi_col_i, row_i + roi_row_i);
            cur_v_nxt     = 1'b1;
            cur_d_nxt     = data_i;
            cur_c_nxt     = col_i;
            cur_w_nxt     = row_i;
            cur_eol_nxt   = eol_i;
            cur_first_nxt = first_r;
            first_nxt     = eol_i;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            cur_v_r     <= 1'b0;
            cur_hit_r   <= 1'b0;
            cur_eol_r   <= 1'b0;
            cur_first_r <= 1'b0;
            first_r     <= 1'b1;
            cur_d_r     <= '0;
            prev_d_r    <= '0;
            cur_c_r     <= '0;
            cur_w_r     <= '0;
            out_v_r     <= 1'b0;
            out_d_r     <= '0;
            out_c_r     <= '0;
            out_w_r     <= '0;
        end
        else
        begin
            cur_v_r     <= cur_v_nxt;
            cur_hit_r   <= cur_hit_nxt;
            cur_eol_r   <= cur_eol_nxt;
            cur_first_r <= cur_first_nxt;
            first_r     <= first_nxt;
            cur_d_r     <= cur_d_nxt;
            prev_d_r    <= prev_d_nxt;
            cur_c_r     <= cur_c_nxt;
            cur_w_r     <= cur_w_nxt;
            out_v_r     <= out_v_nxt;
            out_d_r     <= out_d_nxt;
            out_c_r     <= out_c_nxt;
            out_w_r     <= out_w_nxt;
        end
    end

    assign valid_o = out_v_r;
    assign data_o  = out_d_r;
    assign col_o   = out_c_r;
    assign row_o   = out_w_r;
endmodule

// file: hw/dptc_top.sv
// defect pixel table corrector top
`timescale 1ns/1ns
module dptc_top
    import dptc_pkg::*;
#(
    parameter int DEPTH = DPTC_DEPTH
)(
    // clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    // correction control
    input  wire logic                    static_correction_on_i,
    input  wire dptc_method_type         replacement_method_i,
    input  wire dptc_format_type         pixel_format_i,
    input  wire logic [DPTC_COORD_W-1:0] roi_offset_col_i,
    input  wire logic [DPTC_COORD_W-1:0] roi_offset_row_i,
    // table editing
    input  wire logic                    count_wr_i,
    input  wire logic [DPTC_CNT_W-1:0]   count_wdata_i,
    input  wire logic                    select_wr_i,
    input  wire logic [DPTC_CNT_W-1:0]   select_wdata_i,
    input  wire logic                    column_wr_i,
    input  wire logic [DPTC_COORD_W-1:0] column_wdata_i,
    input  wire logic                    row_wr_i,
    input  wire logic [DPTC_COORD_W-1:0] row_wdata_i,
    // commands, one-cycle pulses
    input  wire logic                    activate_staged_table_i,
    input  wire logic                    persist_table_i,
    input  wire logic                    restore_calibrated_table_i,
    // readback
    output logic      [DPTC_CNT_W-1:0]   table_entry_count_o,
    output logic      [DPTC_CNT_W-1:0]   table_entry_select_o,
    output logic      [DPTC_COORD_W-1:0] entry_column_o,
    output logic      [DPTC_COORD_W-1:0] entry_row_o,
    output logic                         busy_o,
    // persistent store port, one-cycle read latency
    output logic                         nv_rd_en_o,
    output logic                         nv_wr_en_o,
    output logic      [DPTC_CNT_W-1:0]   nv_addr_o,
    output logic      [DPTC_NV_W-1:0]    nv_wdata_o,
    input  wire logic [DPTC_NV_W-1:0]    nv_rdata_i,
    // pixel stream in
    input  wire logic                    pix_valid_i,
    input  wire logic [DPTC_PIX_W-1:0]   pix_data_i,
    input  wire logic [DPTC_COORD_W-1:0] pix_col_i,
    input  wire logic [DPTC_COORD_W-1:0] pix_row_i,
    input  wire logic                    pix_eol_i,
    // pixel stream out
    output logic                         pix_valid_o,
    output logic      [DPTC_PIX_W-1:0]   pix_data_o,
    output logic      [DPTC_COORD_W-1:0] pix_col_o,
    output logic      [DPTC_COORD_W-1:0] pix_row_o
);
    // count word sits one past the last entry
    localparam logic [DPTC_CNT_W-1:0] COUNT_ADDR = DPTC_CNT_W'(DEPTH);

    typedef enum logic [1:0] {
        DPTC_ST_BOOT,
        DPTC_ST_IDLE,
        DPTC_ST_SAVE,
        DPTC_ST_RESTORE
    } dptc_state_type;

    dptc_state_type          st_r, st_nxt;
    logic [DPTC_CNT_W-1:0]   walk_r, walk_nxt;
    logic [DPTC_COORD_W-1:0] stg_col_r [DEPTH];
    logic [DPTC_COORD_W-1:0] stg_col_nxt [DEPTH];
    logic [DPTC_COORD_W-1:0] stg_row_r [DEPTH];
    logic [DPTC_COORD_W-1:0] stg_row_nxt [DEPTH];
    logic [DPTC_COORD_W-1:0] act_col_r [DEPTH];
    logic [DPTC_COORD_W-1:0] act_col_nxt [DEPTH];
    logic [DPTC_COORD_W-1:0] act_row_r [DEPTH];
    logic [DPTC_COORD_W-1:0] act_row_nxt [DEPTH];
    logic [DPTC_CNT_W-1:0]   stg_cnt_r, stg_cnt_nxt, act_cnt_r, act_cnt_nxt;
    logic [DPTC_CNT_W-1:0]   sel_r, sel_nxt;
    logic [DPTC_COORD_W-1:0] rd_col_r, rd_col_nxt, rd_row_r, rd_row_nxt;
    logic                    rd_en_r, rd_en_nxt, wr_en_r, wr_en_nxt, pend_r;
    logic [DPTC_CNT_W-1:0]   addr_r, addr_nxt, pend_addr_r;
    logic [DPTC_NV_W-1:0]    wdata_r, wdata_nxt;
    logic [DPTC_COORD_W-1:0] rom_col, rom_row;
    logic [DPTC_CNT_W-1:0]   rom_cnt;
    logic [DPTC_IDX_W-1:0]   walk_idx, pend_idx;

    // counts above the table size are clamped
    function automatic logic [DPTC_CNT_W-1:0] clamp_cnt(input logic [DPTC_CNT_W-1:0] c);
        return (c > COUNT_ADDR) ? COUNT_ADDR : c;
    endfunction

    assign walk_idx = walk_r[DPTC_IDX_W-1:0];
    assign pend_idx = pend_addr_r[DPTC_IDX_W-1:0];

    dptc_tbl_if #(.DEPTH(DEPTH)) tbl ();

    dptc_factory_rom u_rom (
        .idx_i   (walk_idx),
        .col_o   (rom_col),
        .row_o   (rom_row),
        .count_o (rom_cnt)
    );

    always_comb
    begin
        st_nxt      = st_r;
        walk_nxt    = walk_r;
        stg_col_nxt = stg_col_r;
        stg_row_nxt = stg_row_r;
        act_col_nxt = act_col_r;
        act_row_nxt = act_row_r;
        stg_cnt_nxt = stg_cnt_r;
        act_cnt_nxt = act_cnt_r;
        sel_nxt     = sel_r;
        rd_en_nxt   = 1'b0;
        wr_en_nxt   = 1'b0;
        addr_nxt    = addr_r;
        wdata_nxt   = wdata_r;
        case (st_r)
            DPTC_ST_BOOT:
            begin
                // persistent table read into both copies
                if (walk_r <= COUNT_ADDR)
                begin
                    rd_en_nxt = 1'b1;
                    addr_nxt  = walk_r;
                    walk_nxt  = walk_r + 1'b1;
                end
                if (pend_r)
                begin
                    if (pend_addr_r == COUNT_ADDR)
                    begin
                        stg_cnt_nxt = clamp_cnt(nv_rdata_i[DPTC_CNT_W-1:0]);
                        act_cnt_nxt = clamp_cnt(nv_rdata_i[DPTC_CNT_W-1:0]);
                        st_nxt      = DPTC_ST_IDLE;
                    end
                    else
                    begin
                        stg_col_nxt[pend_idx] = nv_rdata_i[DPTC_NV_W-1:DPTC_COORD_W];
                        stg_row_nxt[pend_idx] = nv_rdata_i[DPTC_COORD_W-1:0];
                        act_col_nxt[pend_idx] = nv_rdata_i[DPTC_NV_W-1:DPTC_COORD_W];
                        act_row_nxt[pend_idx] = nv_rdata_i[DPTC_COORD_W-1:0];
                    end
                end
            end
            DPTC_ST_IDLE:
            begin
                if (count_wr_i)
                begin
                    stg_cnt_nxt = clamp_cnt(count_wdata_i);
                end
                if (select_wr_i)
                begin
                    sel_nxt = select_wdata_i;
                end
                if (column_wr_i && (sel_r < COUNT_ADDR))
                begin
                    stg_col_nxt[sel_r[DPTC_IDX_W-1:0]] = column_wdata_i;
                end
                if (row_wr_i && (sel_r < COUNT_ADDR))
                begin
                    stg_row_nxt[sel_r[DPTC_IDX_W-1:0]] = row_wdata_i;
                end
                walk_nxt = '0;
                if (restore_calibrated_table_i)
                begin
                    // correction paused while the list is rewritten
                    act_cnt_nxt = '0;
                    st_nxt      = DPTC_ST_RESTORE;
                end
                else if (persist_table_i)
                begin
                    st_nxt = DPTC_ST_SAVE;
                end
                else if (activate_staged_table_i)
                begin
                    // whole copy in one cycle, never a torn table
                    act_col_nxt = stg_col_nxt;
                    act_row_nxt = stg_row_nxt;
                    act_cnt_nxt = stg_cnt_nxt;
                end
            end
            DPTC_ST_SAVE:
            begin
                // persistent copy overwritten word by word
                wr_en_nxt = 1'b1;
                addr_nxt  = walk_r;
                walk_nxt  = walk_r + 1'b1;
                if (walk_r == COUNT_ADDR)
                begin
                    wdata_nxt = DPTC_NV_W'(stg_cnt_r);
                    st_nxt    = DPTC_ST_IDLE;
                end
                else
                begin
                    wdata_nxt = {stg_col_r[walk_idx], stg_row_r[walk_idx]};
                end
            end
            default:
            begin
                // calibrated list becomes the current table
                // active and persistent copies both replaced
                wr_en_nxt = 1'b1;
                addr_nxt  = walk_r;
                walk_nxt  = walk_r + 1'b1;
                if (walk_r == COUNT_ADDR)
                begin
                    wdata_nxt   = DPTC_NV_W'(rom_cnt);
                    stg_cnt_nxt = rom_cnt;
                    act_cnt_nxt = rom_cnt;
                    st_nxt      = DPTC_ST_IDLE;
                end
                else
                begin
                    wdata_nxt             = {rom_col, rom_row};
                    stg_col_nxt[walk_idx] = rom_col;
                    stg_row_nxt[walk_idx] = rom_row;
                    act_col_nxt[walk_idx] = rom_col;
                    act_row_nxt[walk_idx] = rom_row;
                end
            end
        endcase
        // readback of the selected staged entry
        rd_col_nxt = '0;
        rd_row_nxt = '0;
        if (sel_nxt < COUNT_ADDR)
        begin
            rd_col_nxt = stg_col_nxt[sel_nxt[DPTC_IDX_W-1:0]];
            rd_row_nxt = stg_row_nxt[sel_nxt[DPTC_IDX_W-1:0]];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            st_r        <= DPTC_ST_BOOT;
            walk_r      <= '0;
            stg_cnt_r   <= '0;
            act_cnt_r   <= '0;
            sel_r       <= '0;
            rd_col_r    <= '0;
            rd_row_r    <= '0;
            rd_en_r     <= 1'b0;
            wr_en_r     <= 1'b0;
            pend_r      <= 1'b0;
            addr_r      <= '0;
            pend_addr_r <= '0;
            wdata_r     <= '0;
            for (int k = 0; k < DEPTH; k++)
            begin
                stg_col_r[k] <= '0;
                stg_row_r[k] <= '0;
                act_col_r[k] <= '0;
                act_row_r[k] <= '0;
            end
        end
        else
        begin
            st_r        <= st_nxt;
            walk_r      <= walk_nxt;
            stg_col_r   <= stg_col_nxt;
            stg_row_r   <= stg_row_nxt;
            act_col_r   <= act_col_nxt;
            act_row_r   <= act_row_nxt;
            stg_cnt_r   <= stg_cnt_nxt;
            act_cnt_r   <= act_cnt_nxt;
            sel_r       <= sel_nxt;
            rd_col_r    <= rd_col_nxt;
            rd_row_r    <= rd_row_nxt;
            rd_en_r     <= rd_en_nxt;
            wr_en_r     <= wr_en_nxt;
            pend_r      <= rd_en_r;
            addr_r      <= addr_nxt;
            pend_addr_r <= addr_r;
            wdata_r     <= wdata_nxt;
        end
    end

    assign tbl.col   = act_col_r;
    assign tbl.row   = act_row_r;
    assign tbl.count = act_cnt_r;

    // stream matched against the active copy only
    dptc_pixel_fix #(.DEPTH(DEPTH)) u_fix (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .tbl       (tbl.user),
        .enable_i  (static_correction_on_i),
        .method_i  (replacement_method_i),
        .format_i  (pixel_format_i),
        .roi_col_i (roi_offset_col_i),
        .roi_row_i (roi_offset_row_i),
        .valid_i   (pix_valid_i),
        .data_i    (pix_data_i),
        .col_i     (pix_col_i),
        .row_i     (pix_row_i),
        .eol_i     (pix_eol_i),
        .valid_o   (pix_valid_o),
        .data_o    (pix_data_o),
        .col_o     (pix_col_o),
        .row_o     (pix_row_o)
    );

    assign table_entry_count_o  = stg_cnt_r;
    assign table_entry_select_o = sel_r;
    assign entry_column_o       = rd_col_r;
    assign entry_row_o          = rd_row_r;
    assign busy_o               = (st_r != DPTC_ST_IDLE);
    assign nv_rd_en_o           = rd_en_r;
    assign nv_wr_en_o           = wr_en_r;
    assign nv_addr_o            = addr_r;
    assign nv_wdata_o           = wdata_r;
endmodule

// file: testbench/dptc_nv_model.sv
// persistent store model, one-cycle read latency
`timescale 1ns/1ns
module dptc_nv_model
(
    // clock
    input  wire logic        ref_clk_i,
    // store port
    input  wire logic        rd_en_i,
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    output logic      [23:0] rdata_o
);
    logic [23:0] mem [17];

    initial
    begin
        foreach (mem[i]) mem[i] = 24'h00_0000;
        mem[0]  = 24'h00_5002;
        mem[16] = 24'h00_0001;
    end

    always @(posedge ref_clk_i)
    begin
        if (wr_en_i)
            mem[addr_i] <= wdata_i;
        // boot read; idle bus shows inverse
        rdata_o <= rd_en_i ? mem[addr_i] : ~rdata_o;
    end
endmodule

// file: testbench/dptc_assertions.sv
// concurrent checks on the corrector's ports
`timescale 1ns/1ns
module dptc_checker
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    // host side
    input wire logic        count_wr_i,
    input wire logic [4:0]  count_wdata_i,
    input wire logic        select_wr_i,
    input wire logic [4:0]  select_wdata_i,
    input wire logic        column_wr_i,
    input wire logic [11:0] column_wdata_i,
    input wire logic        persist_table_i,
    input wire logic        restore_calibrated_table_i,
    input wire logic [4:0]  table_entry_count_o,
    input wire logic [4:0]  table_entry_select_o,
    input wire logic [11:0] entry_column_o,
    input wire logic        busy_o,
    // store and stream
    input wire logic        nv_rd_en_o,
    input wire logic        nv_wr_en_o,
    input wire logic [4:0]  nv_addr_o,
    input wire logic        pix_valid_i,
    input wire logic        pix_valid_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_save_go;
        persist_table_i && !restore_calibrated_table_i && !busy_o;
    endsequence
    sequence s_save_run;
        (busy_o && !nv_wr_en_o) ##1 (nv_wr_en_o && nv_addr_o == 5'h00);
    endsequence

    a_save_writes: assert property (s_save_go |=> s_save_run)
        else $error("no save burst");
    a_save_ends: assert property (nv_wr_en_o && nv_addr_o == 5'h10 |=> !nv_wr_en_o)
        else $error("burst overran");
    a_restore_busy: assert property (restore_calibrated_table_i && !busy_o |=> busy_o)
        else $error("restore not taken");
    a_boot_reads: assert property ($rose(rst_n_i) |=> (nv_rd_en_o && nv_addr_o == 5'h00) ##1 nv_rd_en_o [*7])
        else $error("no boot read");
    a_select_echo: assert property (select_wr_i && !busy_o |=> table_entry_select_o == $past(select_wdata_i))
        else $error("select readback wrong");
    a_count_clamp: assert property (count_wr_i && !busy_o |=> table_entry_count_o == ($past(count_wdata_i) > 5'h10 ? 5'h10 : $past(count_wdata_i)))
        else $error("count readback wrong");
    a_column_echo: assert property (column_wr_i && !select_wr_i && !busy_o && table_entry_select_o < 5'h10 |=> entry_column_o == $past(column_wdata_i))
        else $error("column readback wrong");
    a_out_cause: assert property (pix_valid_o |-> $past(pix_valid_i) || $past(pix_valid_i, 2))
        else $error("pixel out without input");
endmodule

bind dptc_top dptc_checker u_chk (.*);

// file: testbench/tb_top.sv
// self-checking bench for the defect pixel table corrector
`timescale 1ns/1ns
module tb_top
    import dptc_pkg::*;
;
    typedef struct packed {logic en; dptc_method_type m; dptc_format_type f;
        logic [11:0] roi, c0, exp;} dptc_row_type;
    dptc_row_type rows [7] = '{
        '{1'b1, DPTC_M_AVERAGE, DPTC_FMT_12, 12'h000, 12'h004, 12'h096},
        '{1'b1, DPTC_M_HIGHLIGHT, DPTC_FMT_8, 12'h000, 12'h004, 12'h0FF},
        '{1'b1, DPTC_M_HIGHLIGHT, DPTC_FMT_10, 12'h000, 12'h004, 12'h3FF},
        '{1'b1, DPTC_M_HIGHLIGHT, DPTC_FMT_12, 12'h000, 12'h004, 12'hFFF},
        '{1'b1, DPTC_M_ZERO, DPTC_FMT_12, 12'h000, 12'h004, 12'h000},
        '{1'b0, DPTC_M_ZERO, DPTC_FMT_12, 12'h000, 12'h004, 12'h3E7},
        '{1'b1, DPTC_M_ZERO, DPTC_FMT_12, 12'h001, 12'h003, 12'h000}};
    logic ref_clk_i, rst_n_i, static_correction_on_i, count_wr_i, select_wr_i, column_wr_i;
    logic row_wr_i, activate_staged_table_i, persist_table_i, restore_calibrated_table_i;
    logic busy_o, nv_rd_en_o, nv_wr_en_o, pix_valid_i, pix_eol_i, pix_valid_o;
    dptc_method_type replacement_method_i;
    dptc_format_type pixel_format_i;
    logic [4:0]  count_wdata_i, select_wdata_i, table_entry_count_o, table_entry_select_o, nv_addr_o;
    logic [11:0] roi_offset_col_i, roi_offset_row_i, column_wdata_i, row_wdata_i, entry_column_o;
    logic [11:0] entry_row_o, pix_data_i, pix_col_i, pix_row_i, pix_data_o, pix_col_o, pix_row_o;
    logic [23:0] nv_wdata_o, nv_rdata_i;
    logic [35:0] q [$];
    int          bad_count = 0;
    int          tests_run = 0;

    dptc_top #(.DEPTH(16)) dut (.*);
    dptc_nv_model nv (.ref_clk_i, .rd_en_i(nv_rd_en_o), .wr_en_i(nv_wr_en_o), .addr_i(nv_addr_o),
        .wdata_i(nv_wdata_o), .rdata_o(nv_rdata_i));

    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
        if (pix_valid_o === 1'b1) q.push_back({pix_row_o, pix_col_o, pix_data_o});

    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pix(string n, logic [11:0] e, logic [35:0] g);
        chk(n, {12'h000, e}, {12'h000, g[11:0]});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic line(logic [11:0] c0, logic [11:0] r);
        q.delete();
        for (int i = 0; i < 3; i++)
        begin
            pix_valid_i <= 1'b1;
            pix_col_i   <= c0 + 12'(i);
            pix_row_i   <= r;
            pix_data_i  <= (i == 0) ? 12'h064 : (i == 1) ? 12'h3E7 : 12'h0C8;
            pix_eol_i   <= (i == 2);
            tick(1);
        end
        pix_valid_i <= 1'b0;
        pix_eol_i   <= 1'b0;
        tick(5);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 200; i++)
        begin
            tick(1);
            if (busy_o === 1'b0) break;
        end
        tick(1);
        chk("busy", 24'h00_0000, {23'h00_0000, busy_o});
    endtask

    initial
    begin
        {rst_n_i, count_wr_i, select_wr_i, column_wr_i, row_wr_i, pix_valid_i, pix_eol_i} = '0;
        {activate_staged_table_i, persist_table_i, restore_calibrated_table_i} = '0;
        {count_wdata_i, select_wdata_i, column_wdata_i, row_wdata_i, static_correction_on_i} = '0;
        {roi_offset_col_i, roi_offset_row_i, pix_data_i, pix_col_i, pix_row_i} = '0;
        replacement_method_i = DPTC_M_AVERAGE;
        pixel_format_i = DPTC_FMT_12;
        tick(8);
        rst_n_i <= 1'b1;
        wait_idle;
        chk("count", 24'h00_0001, {19'h0, table_entry_count_o});
        foreach (rows[k])
        begin
            static_correction_on_i <= rows[k].en;
            replacement_method_i   <= rows[k].m;
            pixel_format_i         <= rows[k].f;
            roi_offset_col_i       <= rows[k].roi;
            tick(1);
            line(rows[k].c0, 12'h002);
            chk_pix("neighbour", 12'h064, q[0]);
            chk_pix("listed", rows[k].exp, q[1]);
            chk("position", {12'h002, rows[k].c0 + 12'h001}, q[1][35:12]);
        end
        roi_offset_col_i <= 12'h000;
        {count_wr_i, select_wr_i, count_wdata_i, select_wdata_i} <= {2'b11, 5'h02, 5'h01};
        tick(1);
        {count_wr_i, select_wr_i, column_wr_i, row_wr_i} <= 4'b0011;
        {column_wdata_i, row_wdata_i} <= {12'h020, 12'h002};
        tick(1);
        {column_wr_i, row_wr_i} <= 2'b00;
        tick(1);
        chk("column", 24'h00_0020, {12'h0, entry_column_o});
        chk("row", 24'h00_0002, {12'h0, entry_row_o});
        chk("select", 24'h00_0001, {19'h0, table_entry_select_o});
        chk("count", 24'h00_0002, {19'h0, table_entry_count_o});
        line(12'h01F, 12'h002);
        chk_pix("staged", 12'h3E7, q[1]);
        activate_staged_table_i <= 1'b1;
        tick(1);
        activate_staged_table_i <= 1'b0;
        tick(1);
        line(12'h01F, 12'h002);
        chk_pix("applied", 12'h000, q[1]);
        persist_table_i <= 1'b1;
        tick(1);
        persist_table_i <= 1'b0;
        wait_idle;
        chk("nv entry", 24'h02_0002, nv.mem[1]);
        chk("nv count", 24'h00_0002, nv.mem[16]);
        restore_calibrated_table_i <= 1'b1;
        tick(1);
        restore_calibrated_table_i <= 1'b0;
        wait_idle;
        chk("count", 24'h00_0004, {19'h0, table_entry_count_o});
        chk("nv count", 24'h00_0004, nv.mem[16]);
        line(12'h00F, 12'h004);
        chk_pix("factory", 12'h000, q[1]);
        line(12'h01F, 12'h002);
        chk_pix("edit gone", 12'h3E7, q[1]);
        rst_n_i <= 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        wait_idle;
        line(12'h00F, 12'h004);
        chk_pix("reboot", 12'h000, q[1]);
        give_verdict;
    end

    // hang guard
    initial
    begin
        #100000;
        bad_count++;
        give_verdict;
    end
endmodule
